/* File: test_usart_baud_wake_loop_attention.sv */
// Bench: transceiver and line peer back to back
`timescale 1ns/1ps
`default_nettype none
module test_usart_baud_wake_loop_attention;
localparam int HOLD = 20;
logic mclk = 1'b0, rst_n = 1'b0, syncMode = 1'b0, charLenSelLo = 1'b0, charLenSelHi = 1'b1;
logic txValid = 1'b0, txNinthBit = 1'b0, rxReady = 1'b1, addressWaitSet = 1'b0, addressWaitClear = 1'b0;
logic rxStatusBitOp = 1'b0, rxIrqEnable = 1'b0, lowPowerEnter = 1'b0, crystalOsc = 1'b0;
logic sendValid = 1'b0, sendAddress = 1'b0, devMute = 1'b0, peerMute = 1'b0;
logic [usbw_pkg::PSR_W-1:0] prescalerSel = 5'h01;
logic [usbw_pkg::DIV_W-1:0] baudDivisor = 11'h000;
logic [7:0] txData = 8'h00, sendData = 8'h00, wakeupEnableReg = 8'h00, wakeupEdgeReg = 8'h00, rxData;
logic txReady, rxValid, rxNinthBit, addressWaitMode, frameError, parityError, overrunError, rxIrq;
logic asleep, wakeRequest, execHold, sendReady, recvValid, recvFrameErr;
logic [8:0] recvData, a, b;
logic [3:0] arm = 4'h9, ninth = 4'h2, take = 4'h6;
logic [8:0] devQ[$];
logic [8:0] peerQ[$];
int badCount = 0, numChecks = 0, seed = 38201, cycles = 0, clkFlips = 0;
logic clkWas = 1'b0;
usbw_link_if link();
usbw_device #(.WAKE_HOLD_CYCLES(HOLD)) i_usbw_device (.mclk, .rst_n, .link(link.device), .prescalerSel,
    .baudDivisor, .syncMode, .charLenSelLo, .charLenSelHi, .parityEnable(1'b1), .parityOdd(1'b0),
    .twoStopBits(1'b0), .txValid, .txReady, .txData, .txNinthBit, .rxValid, .rxReady, .rxData, .rxNinthBit,
    .addressWaitSet, .addressWaitClear, .addressWaitMode, .rxStatusBitOp, .frameError, .parityError,
    .overrunError, .rxIrqEnable, .rxIrq, .lowPowerEnter, .crystalOsc, .wakeupEnableReg, .wakeupEdgeReg,
    .asleep, .wakeRequest, .execHold);
usbw_peer i_usbw_peer (.mclk, .rst_n, .link(link.peer), .sendValid, .sendReady, .sendData, .sendAddress,
    .recvValid, .recvData, .recvFrameErr);
usbw_chk #(.WAKE_HOLD_CYCLES(HOLD)) i_usbw_chk (.mclk, .rst_n, .deviceTx(link.deviceTx), .txReady, .rxValid,
    .rxIrq, .rxIrqEnable, .addressWaitMode, .addressWaitClear, .rxStatusBitOp, .frameError, .parityError,
    .overrunError, .lowPowerEnter, .asleep, .crystalOsc, .wakeRequest, .execHold);
always #2.5 mclk = ~mclk;
always @(posedge mclk) rxIrqEnable <= 1'($random(seed));
// Counts toggles of the sync bit clock
always @(posedge mclk) begin
    clkWas <= link.bitClk;
    if (link.bitClk !== clkWas) clkFlips++;
end
task check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
        badCount++;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
endtask
task giveVerdict;
    if (badCount == 0 && numChecks > 0) begin
        $display("TB: PASS");
    end else begin
        $display("TB: FAIL");
    end
    $finish;
endtask
task tick(input int n);
    repeat (n) @(posedge mclk);
endtask
task devWrite(input logic [8:0] w);
    @(posedge mclk);
    txValid <= 1'b1;
    txData <= w[7:0];
    txNinthBit <= w[8];
    @(posedge mclk);
    while (txReady !== 1'b1) @(posedge mclk);
    txValid <= 1'b0;
endtask
task peerSend(input logic [8:0] w);
    @(posedge mclk);
    sendValid <= 1'b1;
    sendData <= w[7:0];
    sendAddress <= w[8];
    @(posedge mclk);
    while (sendReady !== 1'b1) @(posedge mclk);
    sendValid <= 1'b0;
endtask
task peerIdle;
    @(posedge mclk);
    while (sendReady !== 1'b1) @(posedge mclk);
    tick(8);
endtask
// Start bit length, then centre samples of data and stop
task decodeTx(input int bitT, input logic [8:0] w);
    int n;
    logic [9:0] got;
    n = 0;
    @(posedge mclk iff link.deviceTx === 1'b0);
    while (link.deviceTx === 1'b0) begin
        @(posedge mclk);
        n++;
    end
    tick(bitT / 2);
    got[0] = link.deviceTx;
    for (int i = 1; i < 10; i++) begin
        tick(bitT);
        got[i] = link.deviceTx;
    end
    check(16'(n), 16'(bitT));
    check(16'(got), {7'h01, w});
endtask
always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
        badCount++;
        giveVerdict();
    end
end
always @(posedge mclk) begin
    if (rxValid === 1'b1 && rxReady === 1'b1 && !devMute) begin
        check({rxNinthBit, rxData}, devQ.size() != 0 ? {7'h00, devQ.pop_front()} : 16'hffff);
    end
    if (recvValid === 1'b1 && !peerMute) begin
        check({recvFrameErr, recvData}, peerQ.size() != 0 ? {7'h00, peerQ.pop_front()} : 16'hffff);
    end
end
initial begin
    tick(10);
    rst_n <= 1'b1;
    tick(2);
    a = 9'($random(seed)) | 9'h001;
    b = 9'($random(seed)) | 9'h001;
    peerQ.push_back(a);
    peerQ.push_back(b);
    fork
        begin
            devWrite(a);
            devWrite(b);
        end
        begin
            decodeTx(16, a);
            decodeTx(16, b);
        end
    join
    tick(100);
    check(16'(clkFlips), 16'h0000);
    peerMute = 1'b1;
    for (int k = 0; k < 2; k++) begin
        @(posedge mclk);
        prescalerSel <= 5'(2 + k);
        baudDivisor <= 11'h001;
        syncMode <= 1'(k);
        a = 9'($random(seed)) | 9'h001;
        fork
            devWrite(a);
            decodeTx((k == 0 ? 16 : 2) * 2 * (3 + k) / 2, a);
        join
        tick(200);
    end
    check(16'(clkFlips != 0), 16'h0001);
    prescalerSel <= 5'h01;
    baudDivisor <= 11'h000;
    syncMode <= 1'b0;
    tick(200);
    peerMute = 1'b0;
    rxReady <= 1'b0;
    for (int k = 0; k < 3; k++) begin
        a = 9'($random(seed));
        if (k < 2) devQ.push_back(a);
        peerSend(a);
    end
    peerIdle();
    check(overrunError, 1'b1);
    rxStatusBitOp <= 1'b1;
    tick(1);
    rxStatusBitOp <= 1'b0;
    tick(2);
    check({frameError, parityError, overrunError}, 16'h0000);
    rxReady <= 1'b1;
    tick(4);
    check({rxValid, 8'(devQ.size())}, 16'h0000);
    // arm, skip data, take address and data
    for (int k = 0; k < 4; k++) begin
        addressWaitSet <= arm[k];
        tick(1);
        addressWaitSet <= 1'b0;
        a = {ninth[k], 8'($random(seed))};
        if (take[k]) devQ.push_back(a);
        peerSend(a);
        peerIdle();
        check(addressWaitMode, !take[k]);
    end
    addressWaitClear <= 1'b1;
    tick(1);
    addressWaitClear <= 1'b0;
    charLenSelLo <= 1'b1;
    a = 9'($random(seed));
    devQ.push_back(a);
    peerQ.push_back(a);
    devWrite(a);
    tick(250);
    check(16'(devQ.size() + peerQ.size()), 16'h0000);
    charLenSelLo <= 1'b0;
    // wake source and edge on rx pin
    wakeupEnableReg <= 8'h08;
    wakeupEdgeReg <= 8'h08;
    crystalOsc <= 1'b1;
    rxReady <= 1'b0;
    peerSend(9'h155);
    peerIdle();
    check(rxValid, 1'b1);
    lowPowerEnter <= 1'b1;
    tick(1);
    lowPowerEnter <= 1'b0;
    tick(1);
    check({asleep, rxValid, txReady, link.deviceTx}, 16'h000b);
    devMute = 1'b1;
    rxReady <= 1'b1;
    peerSend(9'h0f0);
    for (int t = 0; t < 100 && wakeRequest !== 1'b1; t++) @(posedge mclk);
    check(wakeRequest, 1'b1);
    tick(HOLD + 10);
    check({asleep, execHold}, 16'h0000);
    peerIdle();
    tick(20);
    devMute = 1'b0;
    giveVerdict();
end
endmodule
`default_nettype wire

/* File: usbw_chk.sv */
// Concurrent checks on the line and the transceiver's user side
`timescale 1ns/1ps
`default_nettype none
module usbw_chk #(
    parameter int WAKE_HOLD_CYCLES = usbw_pkg::WAKE_HOLD_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Line and transmit side
    input wire logic deviceTx,
    input wire logic txReady,
    // Receive side
    input wire logic rxValid,
    input wire logic rxIrq,
    input wire logic rxIrqEnable,
    input wire logic addressWaitMode,
    input wire logic addressWaitClear,
    input wire logic rxStatusBitOp,
    input wire logic frameError,
    input wire logic parityError,
    input wire logic overrunError,
    // Low power
    input wire logic lowPowerEnter,
    input wire logic asleep,
    input wire logic crystalOsc,
    input wire logic wakeRequest,
    input wire logic execHold
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic anyErr;
    int holdRun;
    assign anyErr = frameError | parityError | overrunError;
    // Length of the running hold
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            holdRun <= 0;
        end else begin
            holdRun <= execHold ? holdRun + 1 : 0;
        end
    end
    property p_sleep;
        lowPowerEnter |=> asleep && txReady && !rxValid && !anyErr;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep entry kept status");
    property p_ones;
        lowPowerEnter |=> deviceTx;
    endproperty
    a_ones: assert property (p_ones)
        else $error("line low after sleep entry");
    property p_irq;
        rxIrq == (rxValid && rxIrqEnable);
    endproperty
    a_irq: assert property (p_irq)
        else $error("rx irq wrong");
    property p_errclr;
        rxStatusBitOp |=> !anyErr;
    endproperty
    a_errclr: assert property (p_errclr)
        else $error("errors kept");
    property p_drop;
        addressWaitMode && !rxValid |=> !rxValid || !addressWaitMode;
    endproperty
    a_drop: assert property (p_drop)
        else $error("word taken while waiting");
    property p_auto;
        $fell(addressWaitMode) && !$past(addressWaitClear) |-> rxValid;
    endproperty
    a_auto: assert property (p_auto)
        else $error("wait cleared without word");
    property p_hold;
        wakeRequest && crystalOsc |=> execHold;
    endproperty
    a_hold: assert property (p_hold)
        else $error("no hold after wake");
    property p_holdlen;
        $fell(execHold) |-> holdRun == WAKE_HOLD_CYCLES;
    endproperty
    a_holdlen: assert property (p_holdlen)
        else $error("hold length wrong");
endmodule
`default_nettype wire

/* File: usbw_device.sv */
// Serial transceiver with baud chain, low-power reinit, loopback and address-wait receive
// Overview of operation
// - Async mode: 16x clock, baud=Fc/(16*N*P)
// - Sync mode: final divide by two
// - Software programs divisor minus one
// - Low-power entry: tx empty, clear status
// - Low-power: tx shift all ones, tx and rx buffers emptied
// - Software enables rx-pin falling-edge wake-up
// - Crystal wake: hold execution 256 instruction cycles
// - Both length bits: tx looped into rx
// - Loopback uses nine-bit frame, no parity
// - Software sets address wait, nine bits
// - Ninth bit one marks an address
// - Address wait discards until address, then full
// - Accepted address clears address wait
// - Software re-arms or leaves address wait
// - Ninth bits: tx from control, rx readable
// - Bit operation on status clears errors
// - Low zero, high one: nine bits, no parity
// - Prescaler code zero stops the clock
// - Rx interrupt while not empty and enabled
`timescale 1ns/1ps
`default_nettype none
module usbw_device #(
    parameter int WAKE_HOLD_CYCLES = usbw_pkg::WAKE_HOLD_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Line
    usbw_link_if.device link,
    // Baud and frame configuration
    input wire logic [usbw_pkg::PSR_W-1:0] prescalerSel,
    input wire logic [usbw_pkg::DIV_W-1:0] baudDivisor,
    input wire logic syncMode,
    input wire logic charLenSelLo,
    input wire logic charLenSelHi,
    input wire logic parityEnable,
    input wire logic parityOdd,
    input wire logic twoStopBits,
    // Transmit holding buffer
    input wire logic txValid,
    output logic txReady,
    input wire logic [7:0] txData,
    input wire logic txNinthBit,
    // Receive buffer
    output logic rxValid,
    input wire logic rxReady,
    output logic [7:0] rxData,
    output logic rxNinthBit,
    // Receive control and status
    input wire logic addressWaitSet,
    input wire logic addressWaitClear,
    output logic addressWaitMode,
    input wire logic rxStatusBitOp,
    output logic frameError,
    output logic parityError,
    output logic overrunError,
    input wire logic rxIrqEnable,
    output logic rxIrq,
    // Low power and wake-up
    input wire logic lowPowerEnter,
    input wire logic crystalOsc,
    input wire logic [7:0] wakeupEnableReg,
    input wire logic [7:0] wakeupEdgeReg,
    output logic asleep,
    output logic wakeRequest,
    output logic execHold
);
    typedef struct packed {
        logic [5:0] psAcc;
        logic [usbw_pkg::DIV_W-1:0] divCnt;
        logic clkOut;
        logic pinS1;
        logic pinS2;
        logic pinPrev;
        logic rxPrev;
        logic [7:0] txHold;
        logic tx9Hold;
        logic txEmpty;
        logic [usbw_pkg::TX_FRAME_W-1:0] txShift;
        logic [3:0] txLeft;
        logic [3:0] txPhase;
        logic [usbw_pkg::RX_SHIFT_W-1:0] rxShift;
        logic [3:0] rxPhase;
        logic [3:0] rxIdx;
        logic rxActive;
        logic [1:0][8:0] fifo;
        logic wrPtr;
        logic rdPtr;
        logic [1:0] count;
        logic frameErr;
        logic parityErr;
        logic overrunErr;
        logic addrWait;
        logic asleep;
        logic [usbw_pkg::HOLD_W-1:0] holdCnt;
        logic wakePulse;
    } usbw_dev_s;

    usbw_dev_s st;
    usbw_dev_s next_st;

    logic [1:0] charLen;
    logic nineBit;
    logic sevenBit;
    logic parityOn;
    logic [3:0] nData;
    logic [3:0] ovs;
    logic [3:0] half;
    logic baudTick;
    logic rxIn;
    logic [9:0] word;
    logic [usbw_pkg::RX_SHIFT_W-1:0] aligned;
    logic [3:0] rxLast;
    logic push;
    logic pop;
    logic sampleBit;

    assign charLen = {charLenSelHi, charLenSelLo};
    assign nineBit = charLen[1];
    assign sevenBit = (charLen == usbw_pkg::CHL_SEVEN);
    assign parityOn = parityEnable && !nineBit;
    assign nData = nineBit ? 4'h9 : (sevenBit ? 4'h7 : 4'h8);
    // sixteen or two ticks per bit
    assign ovs = syncMode ? 4'(usbw_pkg::OVS_SYNC - 1) : 4'(usbw_pkg::OVS_ASYNC - 1);
    assign half = syncMode ? 4'h0 : 4'(usbw_pkg::OVS_ASYNC / 2 - 1);
    assign rxIn = (charLen == usbw_pkg::CHL_LOOP) ? st.txShift[0] : st.pinS2;
    assign rxLast = 4'(nData + {3'h0, parityOn} + 4'h1);

    assign txReady = st.txEmpty;
    assign rxValid = (st.count != 2'h0);
    assign rxData = st.fifo[st.rdPtr][7:0];
    assign rxNinthBit = st.fifo[st.rdPtr][8];
    assign addressWaitMode = st.addrWait;
    assign frameError = st.frameErr;
    assign parityError = st.parityErr;
    assign overrunError = st.overrunErr;
    assign rxIrq = rxValid && rxIrqEnable;
    assign asleep = st.asleep;
    assign wakeRequest = st.wakePulse;
    assign execHold = (st.holdCnt != '0);
    assign link.deviceTx = st.txShift[0];
    assign link.bitClk = st.clkOut;

    always_comb begin
        next_st = st;
        baudTick = 1'b0;
        push = 1'b0;
        sampleBit = 1'b0;
        word = '0;
        aligned = '0;
        pop = rxValid && rxReady;
        next_st.pinS1 = link.peerTx;
        next_st.pinS2 = st.pinS1;
        next_st.pinPrev = st.pinS2;
        next_st.rxPrev = rxIn;
        next_st.wakePulse = 1'b0;

        if (prescalerSel == '0) begin
            next_st.psAcc = '0;
            next_st.divCnt = '0;
        end else if (st.psAcc + 6'h2 >= {1'b0, prescalerSel} + 6'h1) begin
            next_st.psAcc = st.psAcc + 6'h2 - {1'b0, prescalerSel} - 6'h1;
            // divide by programmed value plus one
            if (st.divCnt == baudDivisor) begin
                next_st.divCnt = '0;
                baudTick = 1'b1;
            end else begin
                next_st.divCnt = st.divCnt + 1'b1;
            end
        end else begin
            next_st.psAcc = st.psAcc + 6'h2;
        end
        // bit clock out is tick divided by two
        if (baudTick && syncMode) begin
            next_st.clkOut = !st.clkOut;
        end

        // Transmitter
        if (txValid && st.txEmpty) begin
            next_st.txHold = txData;
            next_st.tx9Hold = txNinthBit;
            next_st.txEmpty = 1'b0;
        end
        if (st.txLeft != 4'h0) begin
            if (baudTick) begin
                if (st.txPhase == ovs) begin
                    next_st.txPhase = 4'h0;
                    next_st.txShift = {1'b1, st.txShift[usbw_pkg::TX_FRAME_W-1:1]};
                    next_st.txLeft = st.txLeft - 4'h1;
                end else begin
                    next_st.txPhase = st.txPhase + 4'h1;
                end
            end
        end else if (!st.txEmpty) begin
            if (nineBit) begin
                word = {1'b1, st.tx9Hold, st.txHold};
            end else if (sevenBit) begin
                word = {2'h3, (^st.txHold[6:0]) ^ parityOdd | !parityOn, st.txHold[6:0]};
            end else begin
                word = {1'b1, (^st.txHold) ^ parityOdd | !parityOn, st.txHold};
            end
            next_st.txShift = {1'b1, word, 1'b0};
            next_st.txLeft = 4'(nData + {3'h0, parityOn} + 4'h2 + {3'h0, twoStopBits});
            next_st.txPhase = 4'h0;
            next_st.txEmpty = 1'b1;
        end

        if (rxStatusBitOp) begin
            next_st.frameErr = 1'b0;
            next_st.parityErr = 1'b0;
            next_st.overrunErr = 1'b0;
        end
        if (addressWaitClear) begin
            next_st.addrWait = 1'b0;
        end

        // start on falling edge, sample at centre
        if (!st.rxActive) begin
            if (st.rxPrev && !rxIn) begin
                next_st.rxActive = 1'b1;
                next_st.rxPhase = 4'h0;
                next_st.rxIdx = 4'h0;
            end
        end else if (baudTick) begin
            next_st.rxPhase = (st.rxPhase == ovs) ? 4'h0 : st.rxPhase + 4'h1;
            if (st.rxPhase == ovs) begin
                next_st.rxIdx = st.rxIdx + 4'h1;
            end
            sampleBit = (st.rxPhase == half);
        end
        if (sampleBit) begin
            if (st.rxIdx == 4'h0) begin
                next_st.rxActive = !rxIn;
            end else begin
                next_st.rxShift = {rxIn, st.rxShift[usbw_pkg::RX_SHIFT_W-1:1]};
            end
            if (st.rxIdx == rxLast) begin
                next_st.rxActive = 1'b0;
                aligned = next_st.rxShift >> (4'(usbw_pkg::RX_SHIFT_W) - rxLast);
                word = {1'b0, nineBit ? aligned[8] : 1'b0, sevenBit ? {1'b0, aligned[6:0]} : aligned[7:0]};
                if (!rxIn) begin
                    next_st.frameErr = 1'b1;
                end
                if (parityOn && ((^aligned[rxLast-4'h2 -: 8] ^ (sevenBit & ~aligned[7])) != parityOdd)) begin
                    next_st.parityErr = 1'b1;
                end
                // discard data while waiting for address
                if (nineBit && st.addrWait && !word[8]) begin
                    push = 1'b0;
                end else if (st.count == 2'h2 && !pop) begin
                    next_st.overrunErr = 1'b1;
                end else begin
                    push = 1'b1;
                    next_st.fifo[st.wrPtr] = word[8:0];
                    next_st.wrPtr = !st.wrPtr;
                end
                // ninth bit one is an address
                if (nineBit && st.addrWait && word[8]) begin
                    next_st.addrWait = 1'b0;
                end
            end
        end
        if (addressWaitSet) begin
            next_st.addrWait = 1'b1;
        end
        if (pop) begin
            next_st.rdPtr = !st.rdPtr;
        end
        next_st.count = 2'(st.count + {1'b0, push} - {1'b0, pop});

        // idle timer holds execution after crystal wake
        if (st.holdCnt != '0) begin
            next_st.holdCnt = st.holdCnt - 1'b1;
        end
        // wake on falling rx pin when enabled
        if (st.asleep && wakeupEnableReg[usbw_pkg::WAKE_PIN_BIT] && wakeupEdgeReg[usbw_pkg::WAKE_PIN_BIT]
            && st.pinPrev && !st.pinS2) begin
            next_st.asleep = 1'b0;
            next_st.wakePulse = 1'b1;
            if (crystalOsc) begin
                next_st.holdCnt = usbw_pkg::HOLD_W'(WAKE_HOLD_CYCLES);
            end
        end

        if (lowPowerEnter) begin
            next_st.asleep = 1'b1;
            next_st.txEmpty = 1'b1;
            next_st.count = 2'h0;
            next_st.rdPtr = st.wrPtr;
            next_st.frameErr = 1'b0;
            next_st.parityErr = 1'b0;
            next_st.overrunErr = 1'b0;
            next_st.rxActive = 1'b0;
            next_st.txShift = usbw_pkg::TX_ALL_ONES;
            next_st.txLeft = 4'h0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.pinS1 <= 1'b1;
            st.pinS2 <= 1'b1;
            st.pinPrev <= 1'b1;
            st.rxPrev <= 1'b1;
            st.txEmpty <= 1'b1;
            st.txShift <= usbw_pkg::TX_ALL_ONES;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

/* File: usbw_link_if.sv */
// Serial line between the transceiver and its peer
`timescale 1ns/1ps
`default_nettype none
interface usbw_link_if;
    logic deviceTx;
    logic peerTx;
    logic bitClk;
    modport device (output deviceTx, output bitClk, input peerTx);
    modport peer (input deviceTx, input bitClk, output peerTx);
endinterface
`default_nettype wire

/* File: usbw_peer.sv */
// Line peer: sends and receives nine-bit frames with address marking
`timescale 1ns/1ps
`default_nettype none
module usbw_peer #(
    parameter int BIT_CYCLES = usbw_pkg::PEER_BIT_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Line
    usbw_link_if.peer link,
    // Send side
    input wire logic sendValid,
    output logic sendReady,
    input wire logic [7:0] sendData,
    input wire logic sendAddress,
    // Receive side
    output logic recvValid,
    output logic [8:0] recvData,
    output logic recvFrameErr
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic [usbw_pkg::PEER_FRAME_BITS-1:0] txShift;
        logic [3:0] txLeft;
        logic [15:0] txCnt;
        logic rxActive;
        logic [15:0] rxCnt;
        logic [3:0] rxIdx;
        logic [usbw_pkg::RX_SHIFT_W-1:0] rxShift;
        logic recvValid;
        logic [8:0] recvData;
        logic recvFrameErr;
    } usbw_peer_s;

    usbw_peer_s st;
    usbw_peer_s next_st;

    assign sendReady = (st.txLeft == 4'h0);
    assign recvValid = st.recvValid;
    assign recvData = st.recvData;
    assign recvFrameErr = st.recvFrameErr;
    assign link.peerTx = st.txShift[0];

    always_comb begin
        next_st = st;
        next_st.s1 = link.deviceTx;
        next_st.s2 = st.s1;
        next_st.prev = st.s2;
        next_st.recvValid = 1'b0;
        if (st.txLeft == 4'h0) begin
            if (sendValid) begin
                next_st.txShift = {1'b1, sendAddress, sendData, 1'b0};
                next_st.txLeft = 4'(usbw_pkg::PEER_FRAME_BITS);
                next_st.txCnt = '0;
            end
        end else if (st.txCnt == 16'(BIT_CYCLES - 1)) begin
            next_st.txCnt = '0;
            next_st.txShift = {1'b1, st.txShift[usbw_pkg::PEER_FRAME_BITS-1:1]};
            next_st.txLeft = st.txLeft - 4'h1;
        end else begin
            next_st.txCnt = st.txCnt + 16'h1;
        end
        if (!st.rxActive) begin
            if (st.prev && !st.s2) begin
                next_st.rxActive = 1'b1;
                next_st.rxCnt = '0;
                next_st.rxIdx = 4'h0;
            end
        end else begin
            next_st.rxCnt = (st.rxCnt == 16'(BIT_CYCLES - 1)) ? 16'h0 : st.rxCnt + 16'h1;
            if (st.rxCnt == 16'(BIT_CYCLES - 1)) begin
                next_st.rxIdx = st.rxIdx + 4'h1;
            end
            if (st.rxCnt == 16'(BIT_CYCLES / 2 - 1)) begin
                if (st.rxIdx == 4'h0) begin
                    next_st.rxActive = !st.s2;
                end else begin
                    next_st.rxShift = {st.s2, st.rxShift[usbw_pkg::RX_SHIFT_W-1:1]};
                end
                if (st.rxIdx == 4'(usbw_pkg::PEER_FRAME_BITS - 1)) begin
                    next_st.rxActive = 1'b0;
                    next_st.recvValid = 1'b1;
                    next_st.recvData = st.rxShift[usbw_pkg::RX_SHIFT_W-1:1];
                    next_st.recvFrameErr = !st.s2;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.s1 <= 1'b1;
            st.s2 <= 1'b1;
            st.prev <= 1'b1;
            st.txShift <= '1;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

/* File: usbw_pkg.sv */
// Shared constants for the serial transceiver and its line peer
package usbw_pkg;
    // Core clock and instruction timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int INSTR_CYCLE_NS = 1000;
    localparam int WAKE_DELAY_INSTR = 256;
    localparam int WAKE_HOLD_CYCLES = (WAKE_DELAY_INSTR * INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W = 16;
    // Baud chain
    localparam int PSR_W = 5;
    localparam int DIV_W = 11;
    localparam int OVS_ASYNC = 16;
    localparam int OVS_SYNC = 2;
    localparam int PEER_BIT_CYCLES = 16;
    // Wake-up source and edge bit of the receive pin
    localparam int WAKE_PIN_BIT = 3;
    // Frame layout
    localparam int TX_FRAME_W = 12;
    localparam int RX_SHIFT_W = 10;
    localparam int PEER_FRAME_BITS = 11;
    localparam logic [1:0] CHL_EIGHT = 2'h0;
    localparam logic [1:0] CHL_SEVEN = 2'h1;
    localparam logic [1:0] CHL_NINE = 2'h2;
    localparam logic [1:0] CHL_LOOP = 2'h3;
    localparam logic [TX_FRAME_W-1:0] TX_ALL_ONES = 12'hfff;
endpackage
